// ### rtl/arb_consts.vh
`ifndef ARB_CONSTS_VH
`define ARB_CONSTS_VH

// ==========================================================
// Bus phase divider
// Two system clocks make one bus clock: rise phase, then fall phase
`define BUS_CLK_DIV 2
`define SYS_CLK_MHZ 10

// ==========================================================
// Negation lead before a pin floats, in tenths of a bus cycle
`define NEG_LEAD_TENTHS 15
// Least time, rounded up to system cycles
`define NEG_LEAD_TICKS ((`NEG_LEAD_TENTHS * `BUS_CLK_DIV + 9) / 10)

// ==========================================================
// Grant codes for the internal requesters
`define GRANT_NONE 2'h0
`define GRANT_REFRESH 2'h1
`define GRANT_DMA 2'h2
`define GRANT_CPU 2'h3

// ==========================================================
// Reset levels of the pins
`define RST_GRANT_N 1'b1
`define RST_REQUEST_N 1'b1

`endif

// ### rtl/pin_sync.v
`timescale 1ns/10ps
// ==========================================================
// Two-flop synchroniser for asynchronous pins
module pin_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] INIT = 3'h7
) (
	clock,
	sys_rst,
	pins,
	synced
);
	input wire clock;
	input wire sys_rst;
	input wire [WIDTH-1:0] pins;
	output reg [WIDTH-1:0] synced;

	reg [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= INIT;
			synced <= INIT;
		end else begin
			meta_q <= pins;
			synced <= meta_q;
		end
	end
endmodule // pin_sync

// ### rtl/external_bus_arbitration.v
// Overview of operation
// [R1] Master holds bus until release request low, then grants after current cycle ends.
// [R2] Release request high returns bus; master negates grant and resumes.
// [R3] Released master floats bus pins except clock enable, grant, DMA acknowledges.
// [R4] Before release, memory precharge finishes; open SDRAM banks get precharge command.
// [R5] Grant at fall, address/data float next rise, controls float next fall.
// [R6] Signals to float are negated at least 1.5 bus cycles beforehand.
// [R7] Arbitration inputs are sampled on the falling bus edge.
// [R8] Release request negated at fall: grant negated, controls driven, address next rise.
// [R9] Refresh with no waiting access negates grant; refresh waits for request negation.
// [R10] Refresh with a waiting access keeps grant; access runs first, then refresh.
// [R11] Outside requester should return bus within the refresh interval.
// [R12] Slave starts released and must win arbitration before any external access.
// [R13] Slave asserts bus request in step with a falling edge.
// [R14] Slave sees acknowledge at fall, drives controls negated, address/data at next rise.
// [R15] Slave negates request half cycle after end, floats address, then controls.
// [R16] Slave ignores refresh but still waits for precharge before release.
// [R17] Partial-share mode: strapped master plus enable bit; only shared space arbitrated.
// [R18] Software programs latency two higher when buffers latch the shared SDRAM.
// [R19] Partial-share: request at fall, acknowledge at falls, access next rise, negate after.
// [R20] Outside buffer control follows request, not acknowledge.
// [R21] Slow buffers: outside logic delays request one clock into release request.
// [R22] Partial-share release waits auto-precharge; no own precharge, no shared refresh.
// [R23] Priority: refresh, external requester, DMA, then processor core.
// [R24] No release inside cache fill, 16-byte DMA block, or test-and-set pair.
`timescale 1ns/10ps
`include "arb_consts.vh"

module external_bus_arbitration (
	clock,
	sys_rst,
	mode_slave_pin,
	partial_share_enable,
	bus_release_request_n,
	bus_acknowledge_n,
	cpu_req,
	dma_req,
	refresh_req,
	req_shared,
	cycle_active,
	bus_lock,
	banks_open,
	precharge_done,
	auto_precharge_done,
	cke_in,
	dma_acknowledge_0_in,
	dma_acknowledge_1_in,
	bus_grant_n,
	bus_request_n,
	addr_data_oe,
	control_oe,
	control_negate,
	precharge_cmd,
	grant_pulse,
	grant_code,
	sdram_cke,
	dma_acknowledge_0,
	dma_acknowledge_1
);
	input wire clock;
	input wire sys_rst;
	input wire mode_slave_pin;
	input wire partial_share_enable;
	input wire bus_release_request_n;
	input wire bus_acknowledge_n;
	input wire cpu_req;
	input wire dma_req;
	input wire refresh_req;
	input wire req_shared;
	input wire cycle_active;
	input wire bus_lock;
	input wire banks_open;
	input wire precharge_done;
	input wire auto_precharge_done;
	input wire cke_in;
	input wire dma_acknowledge_0_in;
	input wire dma_acknowledge_1_in;
	output reg bus_grant_n;
	output reg bus_request_n;
	output reg addr_data_oe;
	output reg control_oe;
	output reg control_negate;
	output reg precharge_cmd;
	output reg grant_pulse;
	output reg [1:0] grant_code;
	output reg sdram_cke;
	output reg dma_acknowledge_0;
	output reg dma_acknowledge_1;

	// ==========================================================
	// States
	localparam [3:0] ST_OWN = 4'h0;
	localparam [3:0] ST_PREP = 4'h1;
	localparam [3:0] ST_GNT_A = 4'h2;
	localparam [3:0] ST_GNT_B = 4'h3;
	localparam [3:0] ST_REL = 4'h4;
	localparam [3:0] ST_RETAKE = 4'h5;
	localparam [3:0] ST_SIDLE = 4'h6;
	localparam [3:0] ST_SWAIT = 4'h7;
	localparam [3:0] ST_SSTART = 4'h8;
	localparam [3:0] ST_SBUSY = 4'h9;
	localparam [3:0] ST_SEND1 = 4'ha;
	localparam [3:0] ST_SEND2 = 4'hb;
	localparam [3:0] ST_SEND3 = 4'hc;
	localparam integer LEAD_WIDE = `NEG_LEAD_TICKS;
	localparam [1:0] LEAD_TICKS = LEAD_WIDE[1:0];

	// Fixed priority among internal requesters
	function [1:0] pick;
		input rf;
		input dm;
		input cp;
		begin
			if (rf)
				pick = `GRANT_REFRESH;
			else if (dm)
				pick = `GRANT_DMA;
			else if (cp)
				pick = `GRANT_CPU;
			else
				pick = `GRANT_NONE;
		end
	endfunction

	// ==========================================================
	// Pin synchronisers and bus phase
	wire [2:0] synced;
	wire release_req_n;
	wire ack_n;
	wire strap_slave;
	reg phase_q;
	reg rel_n_q;
	wire rise_en;
	wire fall_en;

	// Strap idles at slave so nothing drives before the strap is known
	pin_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pins({mode_slave_pin, bus_acknowledge_n, bus_release_request_n}),
		.synced(synced)
	);

	assign release_req_n = synced[0];
	assign ack_n = synced[1];
	assign strap_slave = synced[2];
	// Arbitration pins are only looked at in the fall phase
	assign rise_en = ~phase_q;
	assign fall_en = phase_q; // [R7]

	always @(posedge clock) begin
		if (sys_rst) begin
			phase_q <= 1'b0;
			rel_n_q <= 1'b1;
		end else begin
			phase_q <= ~phase_q;
			if (fall_en)
				rel_n_q <= release_req_n; // [R7]
		end
	end

	// ==========================================================
	// Mode strap, caught once after reset release
	reg strap_taken_q;
	reg [1:0] settle_q;
	reg mode_slave_q;
	wire psm;

	// Strap is trusted only after it has crossed both sync stages
	always @(posedge clock) begin
		if (sys_rst) begin
			strap_taken_q <= 1'b0;
			settle_q <= 2'h0;
			mode_slave_q <= 1'b1;
		end else if (!strap_taken_q) begin
			settle_q <= settle_q + 2'h1;
			strap_taken_q <= (settle_q == 2'h2);
			mode_slave_q <= strap_slave;
		end
	end

	assign psm = ~mode_slave_q & partial_share_enable; // [R17]

	// ==========================================================
	// Arbitration state machine
	reg [3:0] state_q;
	reg [1:0] lead_q;
	reg pre_ok_q;
	reg pre_sent_q;
	reg ref_seen_q;
	reg ref_after_q;
	wire access_pend;
	wire refresh_eff;
	wire defer_ref;
	wire slave_pend;
	wire free;

	assign access_pend = cpu_req | dma_req;
	// Slave never refreshes; refresh never targets the shared space
	assign refresh_eff = refresh_req & ~mode_slave_q; // [R16] [R22]
	assign defer_ref = ref_after_q & access_pend; // [R10]
	assign slave_pend = psm ? (access_pend & req_shared) : access_pend;
	assign free = ~cycle_active & ~grant_pulse & ~bus_lock; // [R24]

	always @(posedge clock) begin
		if (sys_rst) begin
			state_q <= ST_OWN;
			bus_grant_n <= `RST_GRANT_N;
			bus_request_n <= `RST_REQUEST_N;
			addr_data_oe <= 1'b0;
			control_oe <= 1'b0;
			control_negate <= 1'b1;
			precharge_cmd <= 1'b0;
			grant_pulse <= 1'b0;
			grant_code <= `GRANT_NONE;
			lead_q <= 2'h0;
			pre_ok_q <= 1'b0;
			pre_sent_q <= 1'b0;
			ref_seen_q <= 1'b0;
			ref_after_q <= 1'b0;
		end else if (!strap_taken_q) begin
			// Slave comes out of reset released, master takes the bus
			state_q <= strap_slave ? ST_SIDLE : ST_OWN; // [R12]
			addr_data_oe <= ~strap_slave;
			control_oe <= ~strap_slave;
		end else begin
			grant_pulse <= 1'b0;
			precharge_cmd <= 1'b0;
			if (control_negate && lead_q != LEAD_TICKS)
				lead_q <= lead_q + 2'h1;
			else if (!control_negate)
				lead_q <= 2'h0;
			case (state_q)
			ST_OWN: begin
				if (rise_en && free) begin
					if (refresh_eff && !defer_ref) begin
						grant_pulse <= 1'b1; // [R23]
						grant_code <= `GRANT_REFRESH;
						ref_after_q <= 1'b0;
					end else if (!psm && !rel_n_q) begin
						state_q <= ST_PREP; // [R1] [R23]
						control_negate <= 1'b1;
						pre_ok_q <= ~banks_open;
						pre_sent_q <= 1'b0;
					end else if (psm && access_pend && req_shared) begin
						state_q <= ST_SIDLE;
					end else if (access_pend) begin
						grant_pulse <= 1'b1;
						grant_code <= pick(1'b0, dma_req, cpu_req);
					end
				end
			end
			ST_PREP: begin
				if (banks_open && !pre_sent_q) begin
					precharge_cmd <= 1'b1; // [R4]
					pre_sent_q <= 1'b1;
				end
				if (precharge_done)
					pre_ok_q <= 1'b1; // [R4]
				if (fall_en && pre_ok_q && lead_q == LEAD_TICKS) begin
					bus_grant_n <= 1'b0; // [R5] [R6]
					state_q <= ST_GNT_A;
				end
			end
			ST_GNT_A: begin
				if (rise_en) begin
					addr_data_oe <= 1'b0; // [R5] [R3]
					state_q <= ST_GNT_B;
				end
			end
			ST_GNT_B: begin
				if (fall_en) begin
					control_oe <= 1'b0; // [R5] [R3]
					state_q <= ST_REL;
					ref_seen_q <= 1'b0;
				end
			end
			ST_REL: begin
				if (fall_en) begin
					if (release_req_n) begin
						bus_grant_n <= 1'b1; // [R2] [R8]
						control_oe <= 1'b1;
						state_q <= ST_RETAKE;
					end else if (refresh_eff && !ref_seen_q) begin
						ref_seen_q <= 1'b1;
						ref_after_q <= access_pend; // [R10]
						if (!access_pend)
							bus_grant_n <= 1'b1; // [R9]
					end
				end
			end
			ST_RETAKE: begin
				if (rise_en) begin
					addr_data_oe <= 1'b1; // [R8]
					control_negate <= 1'b0;
					state_q <= ST_OWN;
				end
			end
			ST_SIDLE: begin
				if (fall_en && slave_pend) begin
					bus_request_n <= 1'b0; // [R13] [R19]
					state_q <= ST_SWAIT;
				end
			end
			ST_SWAIT: begin
				if (fall_en && !ack_n) begin
					control_oe <= 1'b1; // [R14]
					control_negate <= 1'b1;
					state_q <= ST_SSTART;
				end
			end
			ST_SSTART: begin
				if (rise_en) begin
					addr_data_oe <= 1'b1; // [R14] [R19]
					control_negate <= 1'b0;
					grant_pulse <= 1'b1;
					grant_code <= pick(1'b0, dma_req, cpu_req);
					pre_ok_q <= ~banks_open;
					pre_sent_q <= psm;
					state_q <= ST_SBUSY;
				end
			end
			ST_SBUSY: begin
				if (!cycle_active && !grant_pulse && !bus_lock) begin
					if (banks_open && !pre_sent_q) begin
						precharge_cmd <= 1'b1; // [R16]
						pre_sent_q <= 1'b1;
					end
					if ((psm && auto_precharge_done) || (!psm && precharge_done))
						pre_ok_q <= 1'b1; // [R22]
					if (rise_en && pre_ok_q) begin
						control_negate <= 1'b1;
						state_q <= ST_SEND1;
					end
				end
			end
			ST_SEND1: begin
				if (fall_en) begin
					bus_request_n <= 1'b1; // [R15] [R19]
					state_q <= psm ? ST_OWN : ST_SEND2;
					if (psm)
						control_negate <= 1'b0;
				end
			end
			ST_SEND2: begin
				if (fall_en) begin
					addr_data_oe <= 1'b0; // [R15]
					state_q <= ST_SEND3;
				end
			end
			ST_SEND3: begin
				if (fall_en) begin
					control_oe <= 1'b0; // [R15]
					state_q <= ST_SIDLE;
				end
			end
			default: state_q <= ST_OWN;
			endcase
		end
	end

	// ==========================================================
	// Pins that stay driven while the bus is away
	always @(posedge clock) begin
		if (sys_rst) begin
			sdram_cke <= 1'b0;
			dma_acknowledge_0 <= 1'b0;
			dma_acknowledge_1 <= 1'b0;
		end else begin
			sdram_cke <= cke_in; // [R3]
			dma_acknowledge_0 <= dma_acknowledge_0_in;
			dma_acknowledge_1 <= dma_acknowledge_1_in;
		end
	end
endmodule // external_bus_arbitration

// ### verification/arb_checker.sv
`timescale 1ns/10ps
module arb_checker (
	input wire clock,
	input wire sys_rst,
	input wire mode_slave_pin,
	input wire partial_share_enable,
	input wire cke_in,
	input wire dma_acknowledge_0_in,
	input wire dma_acknowledge_1_in,
	input wire bus_lock,
	input wire bus_grant_n,
	input wire bus_request_n,
	input wire addr_data_oe,
	input wire control_oe,
	input wire control_negate,
	input wire precharge_cmd,
	input wire grant_pulse,
	input wire [1:0] grant_code,
	input wire sdram_cke,
	input wire dma_acknowledge_0,
	input wire dma_acknowledge_1
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Arbitration properties
	property p_keep;
		!$past(sys_rst) |-> sdram_cke == $past(cke_in) && dma_acknowledge_0 == $past(dma_acknowledge_0_in)
			&& dma_acknowledge_1 == $past(dma_acknowledge_1_in);
	endproperty
	property p_rel; $fell(bus_grant_n) |=> !addr_data_oe ##1 !control_oe; endproperty
	property p_take; $rose(addr_data_oe) |-> control_oe; endproperty
	property p_order; $fell(control_oe) |-> !addr_data_oe; endproperty
	property p_lead;
		$fell(addr_data_oe) |-> $past(control_negate) && $past(control_negate, 2)
			&& $past(control_negate, 3);
	endproperty
	property p_lock; bus_lock && bus_grant_n |=> bus_grant_n; endproperty
	property p_slv; mode_slave_pin && $rose(addr_data_oe) |-> !bus_request_n; endproperty
	property p_sfree;
		mode_slave_pin && $rose(bus_request_n) |-> ##2 !addr_data_oe ##2 !control_oe;
	endproperty
	property p_pulse; grant_pulse |-> grant_code != 2'h0 ##1 !grant_pulse; endproperty
	property p_pre; precharge_cmd |-> !partial_share_enable ##1 !precharge_cmd; endproperty
	a_keep: assert property (p_keep) else $error("kept pins wrong");
	a_rel: assert property (p_rel) else $error("release order wrong");
	a_take: assert property (p_take) else $error("address before controls");
	a_order: assert property (p_order) else $error("controls float first");
	a_lead: assert property (p_lead) else $error("negation lead short");
	a_lock: assert property (p_lock) else $error("released under lock");
	a_slv: assert property (p_slv) else $error("slave drove unrequested");
	a_sfree: assert property (p_sfree) else $error("slave float timing");
	a_pulse: assert property (p_pulse) else $error("bad grant pulse");
	a_pre: assert property (p_pre) else $error("bad precharge");
	c_rel: cover property ($fell(bus_grant_n));
	c_req: cover property ($fell(bus_request_n));
	c_ref: cover property (grant_pulse && grant_code == 2'h1);
endmodule // arb_checker

bind external_bus_arbitration arb_checker chk_u (.*);

// ### verification/bus_partner.sv
`timescale 1ns/10ps
module bus_partner (
	input wire clock,
	input wire want,
	input wire [3:0] dly,
	input wire bus_request_n,
	output reg bus_release_request_n,
	output reg bus_acknowledge_n
);
	integer n = 0;
	initial begin
		bus_release_request_n = 1'b1;
		bus_acknowledge_n = 1'b1;
	end
	always @(posedge clock) begin
		#1;
		// Bench drops want within a few cycles, well inside any refresh interval
		bus_release_request_n <= !want;
		// Ack tracks request so buffer control keyed on request stays safe
		if (bus_request_n) begin
			bus_acknowledge_n <= 1'b1;
			n = 0;
		end else if (n >= dly)
			bus_acknowledge_n <= 1'b0;
		else
			n = n + 1;
	end
endmodule // bus_partner

// ### verification/tb_external_bus_arbitration.sv
`timescale 1ns/10ps
module tb_external_bus_arbitration;
	reg clock = 1'b0, sys_rst = 1'b1, mode_slave_pin = 1'b0, partial_share_enable = 1'b0;
	reg cpu_req = 1'b0, dma_req = 1'b0, refresh_req = 1'b0, req_shared = 1'b0;
	reg cycle_active = 1'b0, bus_lock = 1'b0, banks_open = 1'b0, precharge_done = 1'b0;
	reg auto_precharge_done = 1'b0, cke_in = 1'b0, dma_acknowledge_0_in = 1'b0, dma_acknowledge_1_in = 1'b0;
	reg want = 1'b0, pre_seen = 1'b0, g;
	reg [3:0] dly = 4'h1;
	reg [1:0] c, e;
	reg [1:0] q[$];
	// LFSR starts at 75321
	reg [16:0] seed = 17'h12639;
	integer bad_count = 0, checks = 0, n, i, p0, pulses = 0, cyc = 0;
	wire bus_release_request_n, bus_acknowledge_n, bus_grant_n, bus_request_n, addr_data_oe;
	wire control_oe, control_negate, precharge_cmd, grant_pulse, sdram_cke;
	wire dma_acknowledge_0, dma_acknowledge_1;
	wire [1:0] grant_code;

	external_bus_arbitration dut_u (
		.clock(clock),
		.sys_rst(sys_rst),
		.mode_slave_pin(mode_slave_pin),
		.partial_share_enable(partial_share_enable),
		.bus_release_request_n(bus_release_request_n),
		.bus_acknowledge_n(bus_acknowledge_n),
		.cpu_req(cpu_req),
		.dma_req(dma_req),
		.refresh_req(refresh_req),
		.req_shared(req_shared),
		.cycle_active(cycle_active),
		.bus_lock(bus_lock),
		.banks_open(banks_open),
		.precharge_done(precharge_done),
		.auto_precharge_done(auto_precharge_done),
		.cke_in(cke_in),
		.dma_acknowledge_0_in(dma_acknowledge_0_in),
		.dma_acknowledge_1_in(dma_acknowledge_1_in),
		.bus_grant_n(bus_grant_n),
		.bus_request_n(bus_request_n),
		.addr_data_oe(addr_data_oe),
		.control_oe(control_oe),
		.control_negate(control_negate),
		.precharge_cmd(precharge_cmd),
		.grant_pulse(grant_pulse),
		.grant_code(grant_code),
		.sdram_cke(sdram_cke),
		.dma_acknowledge_0(dma_acknowledge_0),
		.dma_acknowledge_1(dma_acknowledge_1)
	);
	bus_partner par_u (
		.clock(clock),
		.want(want),
		.dly(dly),
		.bus_request_n(bus_request_n),
		.bus_release_request_n(bus_release_request_n),
		.bus_acknowledge_n(bus_acknowledge_n)
	);

	always #50 clock = ~clock;

	function [16:0] nx(input [16:0] s);
		nx = {s[15:0], s[16] ^ s[13]};
	endfunction
	task tick; @(posedge clock) #1; endtask
	task chk_code(input [1:0] got, input [1:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_lvl(input got, input exp); chk_code({1'b0, got}, {1'b0, exp}); endtask
	task stop_test;
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task rst(input s);
		sys_rst = 1'b1;
		mode_slave_pin = s;
		repeat (6) tick;
		sys_rst = 1'b0;
		repeat (4) tick;
	endtask

	// ==========================================================
	// Far-side memory, bus cycles and the grant model
	always @(posedge clock) begin
		// Pulse sampled before the edge lands, so cycle_active rises the cycle after it
		g = grant_pulse;
		c = grant_code;
		#1;
		seed = nx(seed);
		{cke_in, dma_acknowledge_0_in, dma_acknowledge_1_in} = seed[2:0];
		auto_precharge_done = seed[4];
		precharge_done = pre_seen;
		pre_seen = pre_seen | precharge_cmd;
		bus_lock = cycle_active & seed[5];
		cycle_active = cyc != 0;
		if (cyc != 0)
			cyc = cyc - 1;
		if (g === 1'b1) begin
			cyc = 2;
			cycle_active = 1'b1;
			pulses = pulses + 1;
			e = q.size() ? q.pop_front() : (refresh_req && !mode_slave_pin) ? 2'h1
				: dma_req ? 2'h2 : 2'h3;
			chk_code(c, e);
			if (e == 2'h1) refresh_req = 1'b0;
			else if (e == 2'h2) dma_req = 1'b0;
			else cpu_req = 1'b0;
		end
	end

	initial begin
		#1000000;
		bad_count = bad_count + 1;
		stop_test;
	end

	// ==========================================================
	// Scenarios
	initial begin
		rst(1'b0);
		for (i = 0; i < 12; i = i + 1) begin
			seed = nx(seed);
			{refresh_req, dma_req, cpu_req} = seed[2:0] | 3'h1;
			for (n = 0; n < 80 && (cpu_req | dma_req | refresh_req); n = n + 1) tick;
			chk_lvl(cpu_req | dma_req | refresh_req, 1'b0);
		end
		banks_open = 1'b1;
		want = 1'b1;
		for (n = 0; n < 60 && bus_grant_n !== 1'b0; n = n + 1) tick;
		chk_lvl(bus_grant_n, 1'b0);
		chk_lvl(pre_seen, 1'b1);
		tick;
		chk_lvl(addr_data_oe, 1'b0);
		tick;
		chk_lvl(control_oe, 1'b0);
		cpu_req = 1'b1;
		repeat (4) tick;
		refresh_req = 1'b1;
		q.push_back(2'h3);
		q.push_back(2'h1);
		repeat (10) tick;
		chk_lvl(bus_grant_n, 1'b0);
		want = 1'b0;
		for (n = 0; n < 20 && bus_grant_n !== 1'b1; n = n + 1) tick;
		chk_lvl(control_oe, 1'b1);
		tick;
		chk_lvl(addr_data_oe, 1'b1);
		for (n = 0; n < 80 && (cpu_req | refresh_req); n = n + 1) tick;
		want = 1'b1;
		for (n = 0; n < 60 && bus_grant_n !== 1'b0; n = n + 1) tick;
		p0 = pulses;
		refresh_req = 1'b1;
		for (n = 0; n < 20 && bus_grant_n !== 1'b1; n = n + 1) tick;
		chk_lvl(bus_grant_n, 1'b1);
		repeat (6) tick;
		chk_lvl(pulses == p0, 1'b1);
		want = 1'b0;
		for (n = 0; n < 60 && refresh_req; n = n + 1) tick;
		chk_lvl(refresh_req, 1'b0);
		// Slave: refresh stays pending since only the master refreshes
		rst(1'b1);
		chk_lvl(addr_data_oe, 1'b0);
		refresh_req = 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			dly = i * 5;
			pre_seen = 1'b0;
			cpu_req = 1'b1;
			for (n = 0; n < 30 && bus_request_n !== 1'b0; n = n + 1) tick;
			chk_lvl(bus_request_n, 1'b0);
			for (n = 0; n < 80 && (cpu_req || bus_request_n !== 1'b1); n = n + 1) tick;
			chk_lvl(bus_request_n, 1'b1);
			chk_lvl(pre_seen, 1'b1);
		end
		repeat (10) tick;
		chk_lvl(refresh_req, 1'b1);
		refresh_req = 1'b0;
		rst(1'b0);
		partial_share_enable = 1'b1;
		want = 1'b1;
		pre_seen = 1'b0;
		for (i = 0; i < 2; i = i + 1) begin
			req_shared = i;
			cpu_req = 1'b1;
			for (n = 0; n < 30 && bus_request_n !== !req_shared; n = n + 1) tick;
			chk_lvl(bus_request_n, !req_shared);
			for (n = 0; n < 80 && (cpu_req || bus_request_n !== 1'b1); n = n + 1) tick;
			chk_lvl(bus_grant_n & addr_data_oe, 1'b1);
		end
		chk_lvl(pre_seen, 1'b0);
		stop_test;
	end
endmodule // tb_external_bus_arbitration
